// ### design/serial_ctrl_pkg.sv
// package: register map, field positions, reset values and carrier structs of the serial control block
// Contract
// - tx_irq_on gates the transmit-empty request
// - rx_irq_on gates receive-full and receive-error requests
// - transmit only while send_on set
// - receive only while rx_on set
// - address wait needs multiprocessor format, async mode
// - address wait drops mpb-zero frames, no flags
// - mpb-one frame clears address wait itself
// - tx_done_irq_on gates the transmit-end request
// - async 00: internal clock, pin is port
// - async 01: internal clock, bit-rate clock out
// - async 1X: pin clock at sixteen times
// - sync 0X: internal clock driven on pin
// - sync 1X: pin clock input from outside
// - sync_select chooses async or synchronous mode
// - multiprocessor format ignores parity settings
// - tx_empty_flag held set while send_on clear
package serial_ctrl_pkg;
   // axi4-lite byte addresses
   localparam logic [3:0] SERIAL_CONTROL_ADDR = 4'h0;
   localparam logic [3:0] MODE_ADDR = 4'h4;
   localparam logic [3:0] IRQ_STATUS_ADDR = 4'h8;
   localparam logic [3:0] IRQ_MASK_ADDR = 4'hC;
   // serial_control field positions
   localparam int TX_IRQ_ON_BIT = 7;
   localparam int RX_IRQ_ON_BIT = 6;
   localparam int SEND_ON_BIT = 5;
   localparam int RX_ON_BIT = 4;
   localparam int ADDR_FILTER_WAIT_BIT = 3;
   localparam int TX_DONE_IRQ_ON_BIT = 2;
   localparam int CLOCK_SOURCE_SEL_BIT = 1;
   localparam int CLOCK_SOURCE_SEL_LOW_BIT = 0;
   // mode register fields (sync_select, multi_proc_format_on, parity_on)
   localparam int SYNC_SELECT_BIT = 7;
   localparam int PARITY_ON_BIT = 5;
   localparam int MULTI_PROC_FORMAT_ON_BIT = 2;
   localparam logic [7:0] SERIAL_CONTROL_RST = 8'h00;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [3:0] IRQ_STATUS_RST = 4'h0;
   localparam logic [3:0] IRQ_MASK_RST = 4'h0;
   // irq status bit positions: one per request
   localparam int EV_TX_EMPTY = 0;
   localparam int EV_RX_FULL = 1;
   localparam int EV_RX_ERROR = 2;
   localparam int EV_TX_DONE = 3;
   // bit-rate clock divider: half the internal bit period in clk_i cycles
   localparam int CLK_HZ = 50000000;
   localparam int BIT_RATE_HZ = 1000000;
   localparam logic [7:0] HALF_BIT_CYCLES = 8'(CLK_HZ / BIT_RATE_HZ / 2);
   localparam logic [1:0] AXI_OKAY = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   // events from the receive datapath
   typedef struct packed {
      logic frame_done;
      logic mpb;
      logic data_ok;
      logic framing_err;
      logic overrun;
   } rx_event_s;

   // status conditions from the shift datapath
   typedef struct packed {
      logic tx_empty_cond;
      logic tx_done_cond;
   } tx_status_s;

   typedef struct packed {
      logic tx_empty_irq;
      logic rx_full_irq;
      logic rx_error_irq;
      logic tx_done_irq;
   } irq_req_s;
endpackage

// ### design/serial_sync2.sv
// module: two flip-flop synchroniser for one pin level
`timescale 1ns/100ps
module serial_sync2 (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // level
   input wire logic d_i,
   output logic q_o
);
   logic [1:0] stage_q;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         stage_q <= 2'h0;
      end else begin
         stage_q <= {stage_q[0], d_i};
      end
   end

   assign q_o = stage_q[1];
endmodule // serial_sync2

// ### design/serial_control_reg.sv
// module: serial control register with axi4-lite slave, clock pin steering and interrupt gating
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/100ps
module serial_control_reg (
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // axi4-lite slave
   input wire logic [3:0] s_awaddr_i,
   input wire logic s_awvalid_i,
   output logic s_awready_o,
   input wire logic [31:0] s_wdata_i,
   input wire logic [3:0] s_wstrb_i,
   input wire logic s_wvalid_i,
   output logic s_wready_o,
   output logic [1:0] s_bresp_o,
   output logic s_bvalid_o,
   input wire logic s_bready_i,
   input wire logic [3:0] s_araddr_i,
   input wire logic s_arvalid_i,
   output logic s_arready_o,
   output logic [31:0] s_rdata_o,
   output logic [1:0] s_rresp_o,
   output logic s_rvalid_o,
   input wire logic s_rready_i,
   // datapath side
   input wire serial_ctrl_pkg::rx_event_s rx_event_i,
   input wire serial_ctrl_pkg::tx_status_s tx_status_i,
   output logic tx_run_o,
   output logic rx_run_o,
   output logic rx_accept_o,
   output logic parity_active_o,
   output logic tx_empty_force_o,
   output logic ext_clk_x16_o,
   output logic ext_clk_sync_o,
   output logic ext_clk_tick_o,
   output logic bit_tick_o,
   // flag set strobes to the status register
   output logic rx_full_set_o,
   output logic framing_error_set_o,
   output logic overrun_set_o,
   // serial clock pin (two-way)
   input wire logic serial_clock_pin_i,
   output logic serial_clock_pin_o,
   output logic serial_clock_pin_oe_o,
   output logic port_mode_o,
   // interrupts
   output serial_ctrl_pkg::irq_req_s irq_req_o,
   output logic irq_o
);
   import serial_ctrl_pkg::*;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] mode;
      logic [3:0] irq_status;
      logic [3:0] irq_mask;
      logic aw_held;
      logic [3:0] aw_addr;
      logic w_held;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] div_cnt;
      logic clk_out;
      logic bit_tick;
      logic pin_prev;
      logic pin_rise;
      irq_req_s req_prev;
      logic rx_full_set;
      logic framing_set;
      logic overrun_set;
   } state_s;

   state_s s_q;
   state_s s_d;
   logic pin_sync;
   logic async_mode;
   logic ext_clk;
   logic mp_wait_active;
   logic wr_fire;
   logic [3:0] wr_addr;
   logic [7:0] wr_byte;
   logic [3:0] wr_low;
   irq_req_s req;

   serial_sync2 pin_sync_u (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .d_i(serial_clock_pin_i),
      .q_o(pin_sync)
   );

   assign async_mode = ~s_q.mode[SYNC_SELECT_BIT];
   assign ext_clk = s_q.ctrl[CLOCK_SOURCE_SEL_BIT];
   // wait only counts in async multiprocessor format
   assign mp_wait_active = s_q.ctrl[ADDR_FILTER_WAIT_BIT] & async_mode
      & s_q.mode[MULTI_PROC_FORMAT_ON_BIT];

   // requests are pure gates of condition and enable, so they drop with either
   always_comb begin
      req.tx_empty_irq = tx_status_i.tx_empty_cond & s_q.ctrl[TX_IRQ_ON_BIT];
      req.rx_full_irq = s_q.rx_full_set & s_q.ctrl[RX_IRQ_ON_BIT];
      req.rx_error_irq = (s_q.framing_set | s_q.overrun_set)
         & s_q.ctrl[RX_IRQ_ON_BIT];
      req.tx_done_irq = tx_status_i.tx_done_cond & s_q.ctrl[TX_DONE_IRQ_ON_BIT];
   end

   assign wr_fire = (s_q.aw_held | s_awvalid_i) & (s_q.w_held | s_wvalid_i) & ~s_q.bvalid;
   assign wr_addr = s_q.aw_held ? s_q.aw_addr : s_awaddr_i;
   assign wr_byte = s_q.w_held ? s_q.w_data[7:0] : s_wdata_i[7:0];
   assign wr_low = s_q.w_held ? s_q.w_strb : s_wstrb_i;

   always_comb begin
      logic [3:0] events;
      events = 4'h0;
      s_d = s_q;
      s_d.bit_tick = 1'b0;
      s_d.rx_full_set = 1'b0;
      s_d.framing_set = 1'b0;
      s_d.overrun_set = 1'b0;
      s_d.req_prev = req;
      // write channels are taken independently, then joined
      if (s_awvalid_i && !s_q.aw_held && !wr_fire) begin
         s_d.aw_held = 1'b1;
         s_d.aw_addr = s_awaddr_i;
      end
      if (s_wvalid_i && !s_q.w_held && !wr_fire) begin
         s_d.w_held = 1'b1;
         s_d.w_data = s_wdata_i;
         s_d.w_strb = s_wstrb_i;
      end
      // receive frame handling
      if (rx_event_i.frame_done && s_q.ctrl[RX_ON_BIT]) begin
         if (mp_wait_active && !rx_event_i.mpb) begin
            // frame skipped: no flag strobes at all
         end else begin
            if (mp_wait_active) begin
               s_d.ctrl[ADDR_FILTER_WAIT_BIT] = 1'b0;
            end
            s_d.rx_full_set = rx_event_i.data_ok & ~rx_event_i.overrun;
            s_d.framing_set = rx_event_i.framing_err;
            s_d.overrun_set = rx_event_i.overrun;
         end
      end
      // interrupt status: rising edges of each request
      events = {req.tx_done_irq & ~s_q.req_prev.tx_done_irq,
                req.rx_error_irq & ~s_q.req_prev.rx_error_irq,
                req.rx_full_irq & ~s_q.req_prev.rx_full_irq,
                req.tx_empty_irq & ~s_q.req_prev.tx_empty_irq};
      if (wr_fire) begin
         s_d.aw_held = 1'b0;
         s_d.w_held = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = AXI_OKAY;
         case (wr_addr)
            SERIAL_CONTROL_ADDR: begin
               if (wr_low[0]) begin
                  // a hardware clear of address wait in this cycle is overwritten by the software write
                  s_d.ctrl = wr_byte;
                  if (!wr_byte[ADDR_FILTER_WAIT_BIT]) begin
                     s_d.ctrl[ADDR_FILTER_WAIT_BIT] = 1'b0;
                  end
               end
            end
            MODE_ADDR: begin
               if (wr_low[0]) begin
                  s_d.mode = wr_byte;
               end
            end
            IRQ_STATUS_ADDR: begin
               if (wr_low[0]) begin
                  s_d.irq_status = s_q.irq_status & ~wr_byte[3:0];
               end
            end
            IRQ_MASK_ADDR: begin
               if (wr_low[0]) begin
                  s_d.irq_mask = wr_byte[3:0];
               end
            end
            default: begin
               s_d.bresp = AXI_SLVERR;
            end
         endcase
      end
      // set wins over a clearing write in the same cycle
      s_d.irq_status = s_d.irq_status | events;
      if (s_q.bvalid && s_bready_i) begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.rvalid && s_rready_i) begin
         s_d.rvalid = 1'b0;
      end
      if (s_arvalid_i && !s_q.rvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = AXI_OKAY;
         s_d.rdata = 32'h0;
         case (s_araddr_i)
            SERIAL_CONTROL_ADDR: s_d.rdata[7:0] = s_q.ctrl;
            MODE_ADDR: s_d.rdata[7:0] = s_q.mode;
            IRQ_STATUS_ADDR: s_d.rdata[3:0] = s_q.irq_status;
            IRQ_MASK_ADDR: s_d.rdata[3:0] = s_q.irq_mask;
            default: s_d.rresp = AXI_SLVERR;
         endcase
      end
      // internal bit-rate clock, half period per toggle
      if (s_q.div_cnt == 8'h0) begin
         s_d.div_cnt = HALF_BIT_CYCLES - 8'h1;
         s_d.clk_out = ~s_q.clk_out;
         s_d.bit_tick = s_q.clk_out;
      end else begin
         s_d.div_cnt = s_q.div_cnt - 8'h1;
      end
      // external clock edge finder, reads only the synchronised level
      s_d.pin_prev = pin_sync;
      s_d.pin_rise = pin_sync & ~s_q.pin_prev;
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_q <= '0;
         s_q.ctrl <= SERIAL_CONTROL_RST;
         s_q.mode <= MODE_RST;
         s_q.irq_status <= IRQ_STATUS_RST;
         s_q.irq_mask <= IRQ_MASK_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign s_awready_o = ~s_q.aw_held & ~s_q.bvalid;
   assign s_wready_o = ~s_q.w_held & ~s_q.bvalid;
   assign s_bvalid_o = s_q.bvalid;
   assign s_bresp_o = s_q.bresp;
   assign s_arready_o = ~s_q.rvalid;
   assign s_rvalid_o = s_q.rvalid;
   assign s_rdata_o = s_q.rdata;
   assign s_rresp_o = s_q.rresp;

   assign tx_run_o = s_q.ctrl[SEND_ON_BIT];
   assign rx_run_o = s_q.ctrl[RX_ON_BIT];
   assign tx_empty_force_o = ~s_q.ctrl[SEND_ON_BIT];
   // parity ignored in multiprocessor format
   assign parity_active_o = s_q.mode[PARITY_ON_BIT] & async_mode
      & ~s_q.mode[MULTI_PROC_FORMAT_ON_BIT];
   assign rx_accept_o = ~mp_wait_active;
   assign rx_full_set_o = s_q.rx_full_set;
   assign framing_error_set_o = s_q.framing_set;
   assign overrun_set_o = s_q.overrun_set;

   // pin steering: async 00 port, async 01 clock out, sync 0X clock out, 1X input
   assign port_mode_o = async_mode & ~ext_clk
      & ~s_q.ctrl[CLOCK_SOURCE_SEL_LOW_BIT];
   assign serial_clock_pin_oe_o = ~ext_clk & (~async_mode
      | s_q.ctrl[CLOCK_SOURCE_SEL_LOW_BIT]);
   assign serial_clock_pin_o = s_q.clk_out & serial_clock_pin_oe_o;
   assign ext_clk_x16_o = ext_clk & async_mode;
   assign ext_clk_sync_o = ext_clk & ~async_mode;
   assign ext_clk_tick_o = s_q.pin_rise & ext_clk;
   assign bit_tick_o = s_q.bit_tick & ~ext_clk;

   assign irq_req_o = req;
   assign irq_o = |(s_q.irq_status & s_q.irq_mask);

   AST_TX_REQ_GATE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !s_q.ctrl[TX_IRQ_ON_BIT] |-> !irq_req_o.tx_empty_irq)
      else $error("tx empty request while disabled");
   AST_RX_REQ_GATE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !s_q.ctrl[RX_IRQ_ON_BIT] |-> !(irq_req_o.rx_full_irq | irq_req_o.rx_error_irq))
      else $error("receive request while disabled");
   // a control write must land in the run and force outputs on the next cycle
   AST_TX_RUN: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (wr_fire && wr_addr == SERIAL_CONTROL_ADDR && wr_low[0])
      |=> (tx_run_o == $past(wr_byte[SEND_ON_BIT]) && tx_empty_force_o == !tx_run_o))
      else $error("transmit run mismatch");
   AST_RX_OFF_NO_FLAG: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (rx_event_i.frame_done && !rx_run_o) |=> !(rx_full_set_o | framing_error_set_o))
      else $error("flag set with receiver off");
   AST_SKIP_FRAME: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (rx_event_i.frame_done && mp_wait_active && !rx_event_i.mpb)
      |=> !(rx_full_set_o | framing_error_set_o | overrun_set_o))
      else $error("skipped frame set a flag");
   AST_WAIT_CLEAR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (rx_event_i.frame_done && rx_run_o && mp_wait_active && rx_event_i.mpb && !wr_fire)
      |=> !s_q.ctrl[ADDR_FILTER_WAIT_BIT])
      else $error("address wait not cleared");
   AST_TXDONE_GATE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      irq_req_o.tx_done_irq |-> (tx_status_i.tx_done_cond && s_q.ctrl[TX_DONE_IRQ_ON_BIT]))
      else $error("tx done request without cause");
   AST_PIN_PORT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      port_mode_o |-> !serial_clock_pin_oe_o)
      else $error("pin driven in port mode");
   AST_PIN_OUT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (!ext_clk && (!async_mode || s_q.ctrl[CLOCK_SOURCE_SEL_LOW_BIT]))
      |-> serial_clock_pin_oe_o)
      else $error("clock not driven out");
   AST_PIN_IN: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      ext_clk |-> (!serial_clock_pin_oe_o && !bit_tick_o))
      else $error("pin driven with external clock");
endmodule // serial_control_reg

// ### sim/remote_station.sv
// model: remote station giving the external serial clock and received-frame events
`timescale 1ns/100ps
module remote_station (
   // event clock
   input wire logic clk_i,
   // external clock request
   input wire logic run_clk_i,
   output logic pin_clk_o,
   output logic drive_o,
   // received frames
   output serial_ctrl_pkg::rx_event_s ev_o
);
   import serial_ctrl_pkg::*;
   assign drive_o = run_clk_i;
   initial pin_clk_o = 1'b1;
   initial ev_o = '0;
   // clock only while asked for; odd start delay keeps it out of phase with clk_i
   always begin
      wait (run_clk_i);
      #37;
      while (run_clk_i) begin
         #80 pin_clk_o = ~pin_clk_o;
      end
      pin_clk_o = 1'b1;
   end
   task automatic send(input logic mpb, input logic ok, input logic fe, input logic ov);
      @(posedge clk_i);
      ev_o <= '{1'b1, mpb, ok, fe, ov};
      @(posedge clk_i);
      // qualifiers mean nothing between frames, so they show junk
      ev_o <= '{1'b0, ~mpb, ~ok, ~fe, ~ov};
   endtask
endmodule // remote_station

// ### sim/tb_top.sv
// testbench: register bus, clock pin modes, interrupt gating and address filter
`timescale 1ns/100ps
module tb_top;
   import serial_ctrl_pkg::*;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, run_clk = 0;
   logic [31:0] wdata = 32'h0, rdv, rdata;
   logic awready, wready, bvalid, arready, rvalid, irq, pin_o, pin_oe, pin_i, pclk, pdrv;
   logic [1:0] bresp, rresp, resp;
   logic tx_run, rx_run, rx_acc, par, frc, x16, xs, xt, bt, fs, fes, ovs, port;
   tx_status_s txs = '0;
   rx_event_s ev;
   irq_req_s req;
   int bad_count = 0, n_tests = 0;
   int cnt[5] = '{default:0}, base[5] = '{default:0};
   logic [31:0] mreg[4];
   logic [4:0] pl;
   always #10 clk_i = ~clk_i;
   // pulled-up pin: level comes from whichever side drives it
   assign pin_i = pin_oe ? pin_o : (pdrv ? pclk : 1'b1);
   assign pl = {req.rx_error_irq, req.rx_full_irq, ovs, fes, fs};
   always @(posedge clk_i) begin
      for (int k = 0; k < 5; k++) cnt[k] += int'(pl[k]);
   end
   remote_station stn_u (.clk_i(clk_i), .run_clk_i(run_clk), .pin_clk_o(pclk), .drive_o(pdrv),
      .ev_o(ev));
   serial_control_reg dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .s_awaddr_i(awaddr), .s_awvalid_i(awvalid), .s_awready_o(awready), .s_wdata_i(wdata),
      .s_wstrb_i(wstrb), .s_wvalid_i(wvalid), .s_wready_o(wready), .s_bresp_o(bresp),
      .s_bvalid_o(bvalid), .s_bready_i(bready), .s_araddr_i(araddr), .s_arvalid_i(arvalid),
      .s_arready_o(arready), .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid),
      .s_rready_i(rready), .rx_event_i(ev), .tx_status_i(txs), .tx_run_o(tx_run),
      .rx_run_o(rx_run), .rx_accept_o(rx_acc), .parity_active_o(par), .tx_empty_force_o(frc),
      .ext_clk_x16_o(x16), .ext_clk_sync_o(xs), .ext_clk_tick_o(xt), .bit_tick_o(bt),
      .rx_full_set_o(fs), .framing_error_set_o(fes), .overrun_set_o(ovs),
      .serial_clock_pin_i(pin_i), .serial_clock_pin_o(pin_o), .serial_clock_pin_oe_o(pin_oe),
      .port_mode_o(port), .irq_req_o(req), .irq_o(irq));
   task automatic final_report;
      $display("compares %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // wide enough for a read word joined with a response or a level
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tmo(inout int n);
      n++;
      if (n > 200) begin
         bad_count++;
         $display("[ERR] t=%0t wait ran out got=%h exp=%h", $time, 0, 1);
         final_report();
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      bit ta, tw;
      n = 0;
      ta = 0;
      tw = 0;
      @(posedge clk_i);
      awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1; wvalid <= 1; bready <= 1;
      while (!(ta && tw)) begin
         @(posedge clk_i);
         if (!ta && awready === 1'b1) begin ta = 1; awvalid <= 0; end
         if (!tw && wready === 1'b1) begin tw = 1; wvalid <= 0; end
         tmo(n);
      end
      do begin @(posedge clk_i); tmo(n); end while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 0;
      if (a == SERIAL_CONTROL_ADDR) mreg[0] = {24'h0, d[7:0]};
      if (a == IRQ_MASK_ADDR) mreg[3] = {28'h0, d[3:0]};
   endtask
   task automatic rd(input logic [3:0] a);
      int n;
      n = 0;
      @(posedge clk_i);
      araddr <= a; arvalid <= 1; rready <= 1;
      do begin @(posedge clk_i); tmo(n); end while (arready !== 1'b1);
      arvalid <= 0;
      do begin @(posedge clk_i); tmo(n); end while (rvalid !== 1'b1);
      rdv = rdata;
      resp = rresp;
      rready <= 0;
   endtask
   task automatic delta(input logic [4:0] e);
      for (int k = 0; k < 5; k++) chk(cnt[k] - base[k], e[k]);
      base = cnt;
   endtask
   task automatic frame(input logic mpb, input logic ok, input logic fe, input logic ov);
      stn_u.send(mpb, ok, fe, ov);
      repeat (3) @(posedge clk_i);
   endtask
   task automatic wctl(input logic [7:0] c);
      wr(SERIAL_CONTROL_ADDR, {24'h0, c});
      repeat (2) @(posedge clk_i);
   endtask
   initial begin
      int r, nb, nx, ntg;
      logic [7:0] c;
      logic prv;
      logic [31:0] pv[3];
      pv = '{32'h24, 32'h20, 32'hA0};
      mreg = '{32'(SERIAL_CONTROL_RST), 32'(MODE_RST), 32'(IRQ_STATUS_RST), 32'(IRQ_MASK_RST)};
      void'($urandom(32'h1B3CEC78));
      repeat (10) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         rd(4'(i * 4));
         chk(rdv, mreg[i]);
      end
      chk({port, pin_oe}, 2'b10);
      for (int i = 0; i < 6; i++) begin
         r = $urandom;
         wr(i[0] ? IRQ_MASK_ADDR : SERIAL_CONTROL_ADDR, r);
         chk(resp, AXI_OKAY);
         rd(i[0] ? IRQ_MASK_ADDR : SERIAL_CONTROL_ADDR);
         chk(rdv, mreg[i[0] ? 3 : 0]);
      end
      wr(4'h2, 32'hFF);
      chk(resp, AXI_SLVERR);
      rd(4'h2);
      chk({rdv, resp}, {32'h0, AXI_SLVERR});
      $display("test registers done");
      wctl(8'h20);
      chk({tx_run, rx_run, frc}, 3'b100);
      wctl(8'h10);
      chk({tx_run, rx_run, frc}, 3'b011);
      $display("test enables done");
      for (int m = 0; m < 8; m++) begin
         wr(MODE_ADDR, {24'h0, m[2], 7'h0});
         wctl({6'h0, m[1:0]});
         run_clk <= m[1];
         repeat (4) @(posedge clk_i);
         chk({port, pin_oe, x16, xs}, {!m[2] && !m[1] && !m[0], !m[1] && (m[2] || m[0]),
            !m[2] && m[1], m[2] && m[1]});
         nb = 0;
         nx = 0;
         ntg = 0;
         prv = pin_o;
         repeat (500) begin
            @(posedge clk_i);
            nb += int'(bt);
            nx += int'(xt);
            ntg += int'(pin_oe && pin_o !== prv);
            prv = pin_o;
         end
         chk(nb, m[1] ? 0 : 10);
         chk(ntg, (!m[1] && (m[2] || m[0])) ? 20 : 0);
         chk(m[1] ? 32'(nx inside {[61:64]}) : nx, 32'(m[1]));
         run_clk <= 1'b0;
      end
      $display("test clock modes done");
      for (int i = 0; i < 3; i++) begin
         wr(MODE_ADDR, pv[i]);
         repeat (2) @(posedge clk_i);
         chk(par, i == 1);
      end
      wr(IRQ_STATUS_ADDR, 32'hF);
      for (int i = 0; i < 12; i++) begin
         r = $urandom;
         c = r[7:0] & 8'hE4;
         txs <= tx_status_s'(r[9:8]);
         wctl(c);
         chk({req.tx_empty_irq, req.tx_done_irq}, {r[9] & c[7], r[8] & c[2]});
      end
      txs <= '0;
      wr(IRQ_MASK_ADDR, 32'h0);
      wctl(8'h80);
      wr(IRQ_STATUS_ADDR, 32'hF);
      txs <= 2'b10;
      repeat (3) @(posedge clk_i);
      rd(IRQ_STATUS_ADDR);
      chk({rdv, irq}, {32'h1, 1'b0});
      wr(IRQ_MASK_ADDR, 32'h1);
      repeat (2) @(posedge clk_i);
      chk(irq, 1'b1);
      wr(IRQ_STATUS_ADDR, 32'h1);
      rd(IRQ_STATUS_ADDR);
      chk({rdv, irq}, {32'h0, 1'b0});
      txs <= '0;
      $display("test interrupts done");
      wr(MODE_ADDR, 32'h0);
      base = cnt;
      wctl(8'h40);
      frame(0, 1, 1, 1);
      delta(5'b00000);
      wctl(8'h50);
      frame(0, 1, 1, 0);
      delta(5'b11011);
      wctl(8'h10);
      // an overrun frame leaves the earlier word in place, so no full strobe
      frame(0, 1, 1, 1);
      delta(5'b00110);
      wr(MODE_ADDR, 32'h4);
      wctl(8'h18);
      chk(rx_acc, 1'b0);
      frame(0, 1, 1, 1);
      delta(5'b00000);
      rd(SERIAL_CONTROL_ADDR);
      chk(rdv, 32'h18);
      frame(1, 1, 0, 0);
      delta(5'b00001);
      rd(SERIAL_CONTROL_ADDR);
      chk({rdv, rx_acc}, {32'h10, 1'b1});
      base = cnt;
      wr(MODE_ADDR, 32'h84);
      wctl(8'h18);
      chk(rx_acc, 1'b1);
      frame(0, 1, 0, 0);
      delta(5'b00001);
      $display("test address filter done");
      final_report();
   end
endmodule // tb_top
